// ===== include/adcc_pkg.sv
// Package with the register map, field positions and carrier types of the converter control
package adcc_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_RES_HIGH = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_RES_LOW = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 5'h14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_W = 8;
    localparam int BIT_START = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_FORMAT = 4;
    localparam int CHAN_W = 4;
    localparam int CHAN_LSB = 0;
    localparam int CTRL_LANE = 0;
    localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;

    // ------------------------------------------------------------
    // Result and interrupt layout
    // ------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam logic [RES_W-1:0] RES_RST = 12'h000;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_IGNORED = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    // ------------------------------------------------------------
    // Conversion sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RESET = 3'h2,
        ST_BUSY = 3'h4
    } adcc_state_t;

    // Controls driven toward the analog core
    typedef struct packed {
        logic power;
        logic hold_reset;
        logic go;
        logic [CHAN_W-1:0] channel;
    } adcc_core_req_t;

    // Answer of the analog core
    typedef struct packed {
        logic done;
        logic [RES_W-1:0] data;
    } adcc_core_rsp_t;

endpackage

// ===== core/adcc_fall_det.sv
// Falling edge detector for the start control bit
`timescale 1ns/100ps
module adcc_fall_det (
    input wire logic mclk,   // System clock
    input wire logic rst,    // Async reset, high
    input wire logic level,  // Level to watch
    output logic fall        // High for the cycle after a high-to-low change
);

    logic prev_ff;

    // Last cycle's level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level;
        end
    end

    // High once the level was high and is now low
    assign fall = prev_ff && !level;

endmodule

// ===== core/adcc_result_fmt.sv
// Splits the 12-bit result across the high and low result registers
`timescale 1ns/100ps
module adcc_result_fmt (
    input wire logic [adcc_pkg::RES_W-1:0] raw,   // Captured result
    input wire logic fmt,                         // Format select
    output logic [adcc_pkg::BYTE_W-1:0] res_high, // High register view
    output logic [adcc_pkg::BYTE_W-1:0] res_low   // Low register view
);

    localparam logic [adcc_pkg::NIB_W-1:0] NIB_ZERO = 4'h0;

    wire [adcc_pkg::BYTE_W-1:0] left_high = raw[adcc_pkg::RES_W-1 -: adcc_pkg::BYTE_W];
    wire [adcc_pkg::BYTE_W-1:0] left_low = {raw[adcc_pkg::NIB_W-1:0], NIB_ZERO};
    wire [adcc_pkg::BYTE_W-1:0] right_high = {NIB_ZERO, raw[adcc_pkg::RES_W-1 -: adcc_pkg::NIB_W]};
    wire [adcc_pkg::BYTE_W-1:0] right_low = raw[adcc_pkg::BYTE_W-1:0];

    // Select left or right alignment
    assign res_high = fmt ? right_high : left_high;
    assign res_low = fmt ? right_low : left_low;

endmodule

// ===== core/adcc_ctrl.sv
// Converter control block: Avalon-MM registers, start sequencing and interrupts
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module adcc_ctrl (
    input wire logic mclk,                                   // System clock, 50 MHz
    input wire logic rst,                                    // Async reset, high
    input wire logic [adcc_pkg::ADDR_W-1:0] avs_address,     // Byte address
    input wire logic avs_read,                               // Read request
    input wire logic avs_write,                              // Write request
    input wire logic [adcc_pkg::DATA_W-1:0] avs_writedata,   // Write data
    input wire logic [adcc_pkg::BE_W-1:0] avs_byteenable,    // Byte lanes
    output logic [adcc_pkg::DATA_W-1:0] avs_readdata,        // Read data
    output logic avs_waitrequest,                            // Stall
    input wire adcc_pkg::adcc_core_rsp_t core_rsp,           // From analog core
    output adcc_pkg::adcc_core_req_t core_req,               // To analog core
    output logic irq                                         // Level interrupt
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [adcc_pkg::DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    logic wait_ff;
    logic [adcc_pkg::DATA_W-1:0] rdata_ff;
    logic start_ff;
    logic enable_ff;
    logic format_ff;
    logic [adcc_pkg::CHAN_W-1:0] chan_ff;
    logic [adcc_pkg::RES_W-1:0] result_ff;
    logic [adcc_pkg::IRQ_W-1:0] status_ff;
    logic [adcc_pkg::IRQ_W-1:0] irq_en_ff;
    logic irq_ff;
    adcc_pkg::adcc_state_t state_ff;
    adcc_pkg::adcc_state_t nxt_state;
    adcc_pkg::adcc_core_req_t req_ff;
    adcc_pkg::adcc_core_req_t nxt_req;
    logic [adcc_pkg::DATA_W-1:0] rd_mux;
    logic start_fall;
    logic [adcc_pkg::BYTE_W-1:0] res_high;
    logic [adcc_pkg::BYTE_W-1:0] res_low;

    // Address match
    function automatic logic hit(input logic [adcc_pkg::ADDR_W-1:0] addr,
                                 input logic [adcc_pkg::ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Transfer completes in the cycle waitrequest is low
    wire acc_write = avs_write && !wait_ff;
    wire lane0 = avs_byteenable[adcc_pkg::CTRL_LANE];
    wire wr_ctrl = acc_write && lane0 && hit(avs_address, adcc_pkg::OFF_CTRL);
    wire wr_clr = acc_write && lane0 && hit(avs_address, adcc_pkg::OFF_IRQ_CLR);
    wire wr_en = acc_write && lane0 && hit(avs_address, adcc_pkg::OFF_IRQ_EN);
    // Readdata is registered, so every transfer takes one wait cycle
    wire nxt_wait = !((avs_read || avs_write) && wait_ff);
    wire [adcc_pkg::IRQ_W-1:0] wr_bits = avs_writedata[adcc_pkg::IRQ_W-1:0];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    wire busy = (state_ff == adcc_pkg::ST_BUSY);
    wire launch = (state_ff == adcc_pkg::ST_RESET) && enable_ff && start_fall;
    wire capture = busy && enable_ff && !start_ff && core_rsp.done;
    // A fall while disabled launches nothing and only raises a flag
    wire ignored = start_fall && !enable_ff;
    wire [adcc_pkg::IRQ_W-1:0] events = {ignored, capture};
    wire [adcc_pkg::IRQ_W-1:0] clr_bits = wr_clr ? wr_bits : adcc_pkg::IRQ_RST;
    wire [adcc_pkg::IRQ_W-1:0] nxt_status = events | (status_ff & ~clr_bits);
    wire [adcc_pkg::CTRL_W-1:0] ctrl_view = {start_ff, busy, enable_ff, format_ff, chan_ff};

    adcc_fall_det u_fall (
        .mclk(mclk),
        .rst(rst),
        .level(start_ff),
        .fall(start_fall)
    );

    adcc_result_fmt u_fmt (
        .raw(result_ff),
        .fmt(format_ff),
        .res_high(res_high),
        .res_low(res_low)
    );

    // Next sequencer state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            adcc_pkg::ST_IDLE: begin
                if (enable_ff && start_ff) begin
                    nxt_state = adcc_pkg::ST_RESET;
                end
            end
            adcc_pkg::ST_RESET: begin
                if (!enable_ff) begin
                    nxt_state = adcc_pkg::ST_IDLE;
                end else if (start_fall) begin
                    nxt_state = adcc_pkg::ST_BUSY;
                end
            end
            adcc_pkg::ST_BUSY: begin
                if (!enable_ff) begin
                    nxt_state = adcc_pkg::ST_IDLE;
                end else if (start_ff) begin
                    // Start raised again aborts the run and re-arms
                    nxt_state = adcc_pkg::ST_RESET;
                end else if (core_rsp.done) begin
                    nxt_state = adcc_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = adcc_pkg::ST_IDLE;
            end
        endcase
    end

    // Controls toward the analog core
    always_comb begin
        nxt_req.power = enable_ff;
        nxt_req.hold_reset = start_ff;
        nxt_req.go = launch;
        nxt_req.channel = chan_ff;
    end

    // Read data selection
    always_comb begin
        rd_mux = RD_ZERO;
        if (hit(avs_address, adcc_pkg::OFF_CTRL)) begin
            rd_mux[adcc_pkg::CTRL_W-1:0] = ctrl_view;
        end else if (hit(avs_address, adcc_pkg::OFF_RES_HIGH)) begin
            rd_mux[adcc_pkg::BYTE_W-1:0] = res_high;
        end else if (hit(avs_address, adcc_pkg::OFF_RES_LOW)) begin
            rd_mux[adcc_pkg::BYTE_W-1:0] = res_low;
        end else if (hit(avs_address, adcc_pkg::OFF_IRQ_STAT)) begin
            rd_mux[adcc_pkg::IRQ_W-1:0] = status_ff;
        end else if (hit(avs_address, adcc_pkg::OFF_IRQ_EN)) begin
            rd_mux[adcc_pkg::IRQ_W-1:0] = irq_en_ff;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Bus handshake, one wait cycle per transfer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_ff <= 1'b1;
            rdata_ff <= RD_ZERO;
        end else begin
            wait_ff <= nxt_wait;
            rdata_ff <= rd_mux;
        end
    end

    // Control fields; the busy bit is not writable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_ff <= 1'b0;
            enable_ff <= 1'b0;
            format_ff <= 1'b0;
            chan_ff <= adcc_pkg::CHAN_RST;
        end else if (wr_ctrl) begin
            start_ff <= avs_writedata[adcc_pkg::BIT_START];
            enable_ff <= avs_writedata[adcc_pkg::BIT_ENABLE];
            format_ff <= avs_writedata[adcc_pkg::BIT_FORMAT];
            chan_ff <= avs_writedata[adcc_pkg::CHAN_LSB +: adcc_pkg::CHAN_W];
        end
    end

    // Sequencer state and core controls
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= adcc_pkg::ST_IDLE;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
        end
    end

    // Result capture, only while enabled
    // The raw word is kept; the split is applied on read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_ff <= adcc_pkg::RES_RST;
        end else if (capture) begin
            result_ff <= core_rsp.data;
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_ff <= adcc_pkg::IRQ_RST;
            irq_en_ff <= adcc_pkg::IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_en_ff <= wr_en ? wr_bits : irq_en_ff;
            irq_ff <= |(status_ff & irq_en_ff);
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;
    assign core_req = req_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_go_after_pulse: assert property (core_req.go |-> !$past(start_ff) && $past(start_ff, 2))
        else $error("conversion launched without a full start pulse");

    a_reset_while_high: assert property (start_ff |=> core_req.hold_reset && !busy)
        else $error("converter not held in reset while start is high");

    a_busy_read_only: assert property (wr_ctrl && avs_writedata[adcc_pkg::BIT_BUSY] && !busy
                                       && !launch |=> !busy)
        else $error("write to busy flag changed it");

    a_busy_on_launch: assert property (core_req.go |-> busy ##1 !core_req.go)
        else $error("busy not set when conversion launched");

    a_busy_on_done: assert property (capture |=> !busy && result_ff == $past(core_rsp.data))
        else $error("busy not cleared or result missed at completion");

    a_power_off: assert property (!enable_ff |=> !core_req.power && !busy)
        else $error("converter powered while disabled");

    a_result_kept: assert property (!enable_ff |=> $stable(result_ff))
        else $error("result changed while disabled");

    a_fmt_right: assert property (format_ff |-> res_high == {4'h0, result_ff[11:8]}
                                  && res_low == result_ff[7:0])
        else $error("right aligned split wrong");

    a_fmt_left: assert property (!format_ff |-> res_high == result_ff[11:4]
                                 && res_low == {result_ff[3:0], 4'h0})
        else $error("left aligned split wrong");

    a_irq_level: assert property (capture ##1 irq_en_ff[adcc_pkg::IRQ_DONE] |=> irq)
        else $error("interrupt missing after enabled completion");

    // Bus handshake: one wait cycle, then the answer
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
                                    |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");

    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    // Launch only while powered, never while held in reset
    a_go_powered: assert property (core_req.go |-> core_req.power)
        else $error("conversion launched while powered down");

    a_hold_no_go: assert property (core_req.hold_reset |-> !core_req.go)
        else $error("conversion launched while held in reset");

    a_off_no_go: assert property (!enable_ff |=> !core_req.go)
        else $error("conversion launched after disable");

    // Sticky status: set wins, clear works, otherwise held
    a_status_set: assert property (capture |=> status_ff[adcc_pkg::IRQ_DONE])
        else $error("completion not recorded in status");

    a_ignored_seen: assert property (ignored |=> status_ff[adcc_pkg::IRQ_IGNORED] && !busy)
        else $error("start while disabled not flagged or launched");

    a_status_hold: assert property (status_ff[adcc_pkg::IRQ_DONE]
                                    && !(wr_clr && wr_bits[adcc_pkg::IRQ_DONE])
                                    |=> status_ff[adcc_pkg::IRQ_DONE])
        else $error("status bit lost without a clear");

    a_clear_works: assert property (wr_clr && wr_bits[adcc_pkg::IRQ_DONE] && !capture
                                    |=> !status_ff[adcc_pkg::IRQ_DONE])
        else $error("status bit survived its clear");

    a_irq_masked: assert property (irq_en_ff == adcc_pkg::IRQ_RST |=> !irq)
        else $error("interrupt raised with all sources masked");

    c_full_conversion: cover property (core_req.go ##[1:50] capture);
    c_abort_by_disable: cover property (busy ##1 !enable_ff);
    c_ignored_start: cover property (ignored);
    c_set_clear_clash: cover property (capture && wr_clr && wr_bits[adcc_pkg::IRQ_DONE]);
    c_restart_in_busy: cover property (busy && start_ff);

endmodule

// ===== testbench/adcc_core_model.sv
// Behavioural model of the analog conversion core behind the control block
`timescale 1ns/100ps
module adcc_core_model (
    input wire logic mclk,                        // System clock
    input wire logic rst,                         // Async reset, high
    input wire adcc_pkg::adcc_core_req_t core_req, // Controls from the block
    input wire logic [7:0] lat,                   // Cycles from go to done, less one
    input wire logic [11:0] value,                // Result to deliver
    output adcc_pkg::adcc_core_rsp_t core_rsp     // Answer to the block
);
    logic run_ff;
    logic [7:0] cnt_ff;
    logic [11:0] noise_ff;
    wire logic done_now = run_ff && (cnt_ff == 8'h00);

    // -----------------------------------------------------------
    // Conversion timing
    // -----------------------------------------------------------
    // Power off or held reset kills a running conversion
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_ff <= 1'b0;
            cnt_ff <= 8'h00;
            noise_ff <= 12'h000;
        end else begin
            noise_ff <= noise_ff + 12'h3B1;
            if (!core_req.power || core_req.hold_reset) begin
                run_ff <= 1'b0;
            end else if (core_req.go) begin
                run_ff <= 1'b1;
                cnt_ff <= lat;
            end else if (done_now) begin
                run_ff <= 1'b0;
            end else if (run_ff) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end

    // Data line shows a moving pattern outside done
    assign core_rsp.done = done_now;
    assign core_rsp.data = done_now ? value : noise_ff;
endmodule

// ===== testbench/tb.sv
// Self-checking bench of the converter control block over Avalon-MM
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [adcc_pkg::ADDR_W-1:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [adcc_pkg::DATA_W-1:0] avs_writedata = 32'h00000000;
    logic [adcc_pkg::BE_W-1:0] avs_byteenable = 4'hF;
    logic [adcc_pkg::DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    adcc_pkg::adcc_core_rsp_t core_rsp;
    adcc_pkg::adcc_core_req_t core_req;
    logic irq;
    logic [7:0] lat = 8'h14;
    logic [11:0] value = 12'h000;
    logic [31:0] q;
    int n_errors = 0;
    int total_checks = 0;

    always #10 mclk = ~mclk;

    adcc_ctrl i_adcc_ctrl (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_rsp(core_rsp), .core_req(core_req),
        .irq(irq));
    adcc_core_model i_adcc_core_model (.mclk(mclk), .rst(rst), .core_req(core_req),
        .lat(lat), .value(value), .core_rsp(core_rsp));

    // -----------------------------------------------------------
    // Bus tasks
    // -----------------------------------------------------------
    task automatic final_report;
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] r);
        int n;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= ~w;
        for (n = 0; n < 16; n++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        r = avs_readdata;
        if (n == 16) begin
            n_errors++;
            final_report();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 4'hF, r);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, 4'hF, r);
        `CHK(nm, e, r)
    endtask

    // Polls the control register until the busy flag drops
    task automatic wait_idle;
        logic [31:0] r;
        int n;
        for (n = 0; n < 60; n++) begin
            bus(1'b0, adcc_pkg::OFF_CTRL, 8'h00, 4'hF, r);
            if (r[adcc_pkg::BIT_BUSY] === 1'b0) break;
        end
        if (n == 60) begin
            n_errors++;
            final_report();
        end
    endtask

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        `CHK("core_req", 7'h00, core_req)
        rd(adcc_pkg::OFF_CTRL, 32'h00000000, "ctrl");
        rd(5'h18, 32'h00000000, "unmapped");
        wr(adcc_pkg::OFF_IRQ_EN, 8'h01);
        // Start pulse while disabled: refused, event masked
        wr(adcc_pkg::OFF_CTRL, 8'h90);
        wr(adcc_pkg::OFF_CTRL, 8'h10);
        rd(adcc_pkg::OFF_CTRL, 32'h00000010, "ctrl");
        rd(adcc_pkg::OFF_IRQ_STAT, 32'h00000002, "stat");
        `CHK("irq", 1'b0, irq)
        wr(adcc_pkg::OFF_IRQ_CLR, 8'h02);
        wr(adcc_pkg::OFF_CTRL, 8'h60);
        rd(adcc_pkg::OFF_CTRL, 32'h00000020, "ctrl");
        `CHK("power", 1'b1, core_req.power)
        // Slow conversion, format 0
        value <= 12'hABC;
        wr(adcc_pkg::OFF_CTRL, 8'hA0);
        rd(adcc_pkg::OFF_CTRL, 32'h000000A0, "ctrl");
        `CHK("hold_reset", 1'b1, core_req.hold_reset)
        wr(adcc_pkg::OFF_CTRL, 8'h20);
        rd(adcc_pkg::OFF_CTRL, 32'h00000060, "busy");
        wait_idle();
        rd(adcc_pkg::OFF_RES_HIGH, 32'h000000AB, "res_high");
        rd(adcc_pkg::OFF_RES_LOW, 32'h000000C0, "res_low");
        rd(adcc_pkg::OFF_IRQ_STAT, 32'h00000001, "stat");
        `CHK("irq", 1'b1, irq)
        wr(adcc_pkg::OFF_IRQ_CLR, 8'h01);
        rd(adcc_pkg::OFF_IRQ_STAT, 32'h00000000, "stat");
        `CHK("irq", 1'b0, irq)
        // Format 1 re-splits the stored result
        wr(adcc_pkg::OFF_CTRL, 8'h30);
        rd(adcc_pkg::OFF_RES_HIGH, 32'h0000000A, "res_high");
        rd(adcc_pkg::OFF_RES_LOW, 32'h000000BC, "res_low");
        // Disable in mid-conversion
        value <= 12'h123;
        wr(adcc_pkg::OFF_CTRL, 8'hB0);
        wr(adcc_pkg::OFF_CTRL, 8'h30);
        wr(adcc_pkg::OFF_CTRL, 8'h10);
        rd(adcc_pkg::OFF_CTRL, 32'h00000010, "ctrl");
        `CHK("power", 1'b0, core_req.power)
        rd(adcc_pkg::OFF_RES_HIGH, 32'h0000000A, "res_high");
        rd(adcc_pkg::OFF_RES_LOW, 32'h000000BC, "res_low");
        // Prompt core, back-to-back writes
        lat <= 8'h00;
        value <= 12'h5A3;
        wr(adcc_pkg::OFF_CTRL, 8'h30);
        wr(adcc_pkg::OFF_CTRL, 8'hB0);
        wr(adcc_pkg::OFF_CTRL, 8'h30);
        wait_idle();
        rd(adcc_pkg::OFF_RES_HIGH, 32'h00000005, "res_high");
        rd(adcc_pkg::OFF_RES_LOW, 32'h000000A3, "res_low");
        // Write with lane 0 off is ignored
        bus(1'b1, adcc_pkg::OFF_CTRL, 8'h00, 4'h0, q);
        rd(adcc_pkg::OFF_CTRL, 32'h00000030, "ctrl");
        // Channel field is stored and passed to the core
        wr(adcc_pkg::OFF_CTRL, 8'h35);
        rd(adcc_pkg::OFF_CTRL, 32'h00000035, "ctrl");
        `CHK("channel", 4'h5, core_req.channel)
        final_report();
    end
endmodule
